/* pkg/dtm_pkg.sv */
// Purpose: Shared constants for the training-mode block of the memory die
// Assumes: Mode register addresses are six bits, data eight bits
// Notes:   Times are in ns; cycle counts derive from the system clock period
package dtm_pkg;

  // Mode register addresses
  localparam logic [5:0] MRA_LAT_WL = 6'h02;     // Read latency [2:0], leveling enable [7]
  localparam logic [5:0] MRA_DBI = 6'h03;        // Read inversion enable [6]
  localparam logic [5:0] MRA_REF = 6'h0c;        // Reference setting [5:0], range [6]
  localparam logic [5:0] MRA_SP_CTRL = 6'h0d;    // Set-point control
  localparam logic [5:0] MRA_MASK_LO = 6'h0f;
  localparam logic [5:0] MRA_MASK_HI = 6'h14;
  localparam logic [5:0] MRA_PAT_FIRST = 6'h20;
  localparam logic [5:0] MRA_PAT_SECOND = 6'h28;

  // Field positions
  localparam int RL_MSB = 2;
  localparam int WL_EN_BIT = 7;
  localparam int DBI_RD_BIT = 6;
  localparam int REF_RANGE_BIT = 6;
  localparam int REFERENCE_CURRENT_MODE_BIT = 3;
  localparam int WR_SEL_BIT = 6;
  localparam int OP_SEL_BIT = 7;

  // Reset values
  localparam logic [7:0] PAT_FIRST_RST = 8'h5a;
  localparam logic [7:0] PAT_SECOND_RST = 8'h3c;
  localparam logic [7:0] MASK_RST = 8'h55;
  localparam logic [6:0] REF_RST = 7'h0d;
  localparam logic [2:0] RL_RST = 3'h0;

  // Set-point switch time classes
  localparam logic [1:0] CLASS_NONE = 2'h0;
  localparam logic [1:0] CLASS_SHORT = 2'h1;
  localparam logic [1:0] CLASS_MIDDLE = 2'h2;
  localparam logic [1:0] CLASS_LONG = 2'h3;

  // Calibration burst
  localparam int BURST_BEATS = 16;
  localparam logic [7:0] RL_BASE = 8'h03;        // Link cycles added to the latency field

  // Leveling feedback delay, a longest time, so rounded down
  localparam int SYS_PERIOD_NS = 10;
  localparam int LEVELING_FEEDBACK_NS = 20;
  localparam int FB_CYC = (LEVELING_FEEDBACK_NS / SYS_PERIOD_NS < 1) ? 1 :
                          LEVELING_FEEDBACK_NS / SYS_PERIOD_NS;

endpackage

/* rtl/dtm_training.sv */
// Purpose: Training modes of a low-power memory die: set-point switching,
//          write leveling feedback and read data calibration bursts
// Assumes: Commands and mode register writes arrive on the link clock;
//          one calibration beat per link clock cycle
// Notes:   Leveling logic runs on the system clock so a stopped link clock
//          does not freeze the feedback path
`timescale 1ns/1ps

module dtm_training #(
  parameter int DQ_WIDTH = 16,
  parameter int BURST_LEN = dtm_pkg::BURST_BEATS
) (
  // System side
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Link clock and command decode outputs
  input wire logic i_ck_link,
  input wire logic i_mrw_valid,
  input wire logic [5:0] i_mrw_addr,
  input wire logic [7:0] i_mrw_data,
  input wire logic i_cal_cmd,
  input wire logic i_cas2,
  input wire logic [5:0] i_cas2_op,
  // Pins sampled for leveling
  input wire logic [1:0] i_dqs,
  input wire logic i_ck_level,
  // Data pins
  output logic [15:0] o_dq,
  output logic [15:0] o_dq_oe,
  output logic [1:0] o_dmi,
  output logic [1:0] o_dmi_oe,
  // Status
  output logic o_op_set_point,
  output logic o_wr_set_point,
  output logic o_ref_fast,
  output logic [1:0] o_switch_class,
  output logic o_cal_busy,
  output logic o_leveling
);

  // Elaboration check: the pin mux and beat counter are sized for these values only
  if (DQ_WIDTH != 16 || BURST_LEN != dtm_pkg::BURST_BEATS) begin : g_param_check
    $error("dtm_training: only a 16-bit bus and 16-beat burst are served");
  end

  typedef enum logic [3:0] {
    CAL_IDLE = 4'h1,
    CAL_WAIT_CAS = 4'h2,
    CAL_LAT = 4'h4,
    CAL_BURST = 4'h8
  } dtm_cal_e;

  // Absolute step distance classified into a switch time class
  function automatic logic [1:0] switch_class(input logic [6:0] a, input logic [6:0] b);
    logic [5:0] diff;
    diff = (a[5:0] > b[5:0]) ? a[5:0] - b[5:0] : b[5:0] - a[5:0];
    if (a[dtm_pkg::REF_RANGE_BIT] != b[dtm_pkg::REF_RANGE_BIT]) begin
      switch_class = dtm_pkg::CLASS_LONG;
    end else if (diff >= 6'h02) begin
      switch_class = dtm_pkg::CLASS_MIDDLE;
    end else if (diff == 6'h01) begin
      switch_class = dtm_pkg::CLASS_SHORT;
    end else begin
      switch_class = dtm_pkg::CLASS_NONE;
    end
  endfunction

  // ---------------- Link domain: mode registers ----------------
  logic [7:0] pat0_q, pat0_d, pat1_q, pat1_d, mlo_q, mlo_d, mhi_q, mhi_d;
  logic wr_sel_q, wr_sel_d, op_sel_q, op_sel_d, reference_current_mode_q, reference_current_mode_d, wl_en_q, wl_en_d;
  logic [6:0] ref_q [2];
  logic [6:0] ref_d [2];
  logic [2:0] rl_q [2];
  logic [2:0] rl_d [2];
  logic [1:0] dbi_q, dbi_d, class_q, class_d;

  // Reference, inversion and latency writes land in the copy picked by the write select
  always_comb begin
    pat0_d = pat0_q;
    pat1_d = pat1_q;
    mlo_d = mlo_q;
    mhi_d = mhi_q;
    wr_sel_d = wr_sel_q;
    op_sel_d = op_sel_q;
    reference_current_mode_d = reference_current_mode_q;
    wl_en_d = wl_en_q;
    ref_d = ref_q;
    rl_d = rl_q;
    dbi_d = dbi_q;
    class_d = class_q;
    if (i_mrw_valid) begin
      case (i_mrw_addr)
        dtm_pkg::MRA_PAT_FIRST: pat0_d = i_mrw_data;
        dtm_pkg::MRA_PAT_SECOND: pat1_d = i_mrw_data;
        dtm_pkg::MRA_MASK_LO: mlo_d = i_mrw_data;
        dtm_pkg::MRA_MASK_HI: mhi_d = i_mrw_data;
        dtm_pkg::MRA_REF: ref_d[wr_sel_q] = i_mrw_data[6:0];
        dtm_pkg::MRA_DBI: dbi_d[wr_sel_q] = i_mrw_data[dtm_pkg::DBI_RD_BIT];
        dtm_pkg::MRA_LAT_WL: begin
          rl_d[wr_sel_q] = i_mrw_data[dtm_pkg::RL_MSB:0];
          wl_en_d = i_mrw_data[dtm_pkg::WL_EN_BIT];
        end
        dtm_pkg::MRA_SP_CTRL: begin
          wr_sel_d = i_mrw_data[dtm_pkg::WR_SEL_BIT];
          op_sel_d = i_mrw_data[dtm_pkg::OP_SEL_BIT];
          reference_current_mode_d = i_mrw_data[dtm_pkg::REFERENCE_CURRENT_MODE_BIT];
          if (i_mrw_data[dtm_pkg::OP_SEL_BIT] != op_sel_q) begin
            class_d = switch_class(ref_q[0], ref_q[1]);
          end
        end
        default: ;
      endcase
    end
  end

  // Both copies power up with the same low-speed defaults
  always_ff @(posedge i_ck_link or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pat0_q <= dtm_pkg::PAT_FIRST_RST;
      pat1_q <= dtm_pkg::PAT_SECOND_RST;
      mlo_q <= dtm_pkg::MASK_RST;
      mhi_q <= dtm_pkg::MASK_RST;
      wr_sel_q <= 1'b0;
      op_sel_q <= 1'b0;
      reference_current_mode_q <= 1'b0;
      wl_en_q <= 1'b0;
      ref_q <= '{dtm_pkg::REF_RST, dtm_pkg::REF_RST};
      rl_q <= '{dtm_pkg::RL_RST, dtm_pkg::RL_RST};
      dbi_q <= 2'h0;
      class_q <= dtm_pkg::CLASS_NONE;
    end else begin
      pat0_q <= pat0_d;
      pat1_q <= pat1_d;
      mlo_q <= mlo_d;
      mhi_q <= mhi_d;
      wr_sel_q <= wr_sel_d;
      op_sel_q <= op_sel_d;
      reference_current_mode_q <= reference_current_mode_d;
      wl_en_q <= wl_en_d;
      ref_q <= ref_d;
      rl_q <= rl_d;
      dbi_q <= dbi_d;
      class_q <= class_d;
    end
  end

  assign o_op_set_point = op_sel_q;
  assign o_wr_set_point = wr_sel_q;
  assign o_ref_fast = reference_current_mode_q;
  assign o_switch_class = class_q;

  // ---------------- Link domain: calibration burst ----------------
  dtm_cal_e state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [3:0] beat_q, beat_d;
  logic [15:0] snap_pat_q, snap_pat_d, snap_msk_q, snap_msk_d;
  logic [15:0] cal_dq_q, cal_dq_d;
  logic [1:0] cal_dmi_q, cal_dmi_d;
  logic cal_drv_q, cal_drv_d;
  logic [3:0] next_beat;
  logic pat_bit;

  // Beat data is precomputed so the pins come straight from flops
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    beat_d = beat_q;
    snap_pat_d = snap_pat_q;
    snap_msk_d = snap_msk_q;
    next_beat = (state_q == CAL_BURST) ? beat_q + 4'h1 : 4'h0;
    case (state_q)
      CAL_IDLE: begin
        // Bank and refresh state play no part in acceptance
        if (i_cal_cmd && !wl_en_q) begin
          state_d = CAL_WAIT_CAS;
        end
      end
      CAL_WAIT_CAS: begin
        // A late or dirty second cycle drops the request
        if (i_cas2 && i_cas2_op == 6'h00) begin
          state_d = CAL_LAT;
          cnt_d = 8'(rl_q[op_sel_q]) + dtm_pkg::RL_BASE;
          snap_pat_d = {pat1_q, pat0_q};
          snap_msk_d = {mhi_q, mlo_q};
        end else begin
          state_d = CAL_IDLE;
        end
      end
      CAL_LAT: begin
        if (cnt_q == 8'h01) begin
          state_d = CAL_BURST;
          beat_d = 4'h0;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      CAL_BURST: begin
        beat_d = next_beat;
        if (beat_q == 4'(BURST_LEN - 1)) begin
          state_d = CAL_IDLE;
        end
      end
      default: state_d = CAL_IDLE;
    endcase
    // First byte low bit first, then second byte
    pat_bit = snap_pat_d[next_beat];
    cal_drv_d = (state_d == CAL_BURST);
    cal_dq_d = {16{pat_bit}} ^ snap_msk_d;
    cal_dmi_d = {2{pat_bit}};
  end

  always_ff @(posedge i_ck_link or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= CAL_IDLE;
      cnt_q <= 8'h00;
      beat_q <= 4'h0;
      snap_pat_q <= 16'h0000;
      snap_msk_q <= 16'h0000;
      cal_dq_q <= 16'h0000;
      cal_dmi_q <= 2'h0;
      cal_drv_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      beat_q <= beat_d;
      snap_pat_q <= snap_pat_d;
      snap_msk_q <= snap_msk_d;
      cal_dq_q <= cal_dq_d;
      cal_dmi_q <= cal_dmi_d;
      cal_drv_q <= cal_drv_d;
    end
  end

  assign o_cal_busy = (state_q != CAL_IDLE);

  // ---------------- System domain: write leveling ----------------
  logic wl_s1_q, wl_s2_q, ck_s1_q, ck_s2_q;
  logic [1:0] dqs_s1_q, dqs_s2_q, dqs_s3_q;
  logic [1:0] lvl_q, lvl_d;
  logic [1:0] fb_pipe_q [dtm_pkg::FB_CYC];
  logic [1:0] fb_pipe_d [dtm_pkg::FB_CYC];
  logic [1:0] dqs_rise;

  // Each byte keeps its own sample; every rising strobe edge while leveling overwrites it, and leaving leveling clears it
  always_comb begin
    dqs_rise = dqs_s2_q & ~dqs_s3_q;
    lvl_d = lvl_q;
    for (int b = 0; b < 2; b++) begin
      if (!wl_s2_q) begin
        lvl_d[b] = 1'b0;
      end else if (dqs_rise[b]) begin
        lvl_d[b] = ck_s2_q;
      end
    end
    fb_pipe_d[0] = lvl_q;
    for (int i = 1; i < dtm_pkg::FB_CYC; i++) begin
      fb_pipe_d[i] = fb_pipe_q[i - 1];
    end
  end

  // Two flops on every pin and on the enable from the link domain, and a third flop on the strobes
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wl_s1_q <= 1'b0;
      wl_s2_q <= 1'b0;
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      dqs_s1_q <= 2'h0;
      dqs_s2_q <= 2'h0;
      dqs_s3_q <= 2'h0;
      lvl_q <= 2'h0;
      for (int i = 0; i < dtm_pkg::FB_CYC; i++) begin
        fb_pipe_q[i] <= 2'h0;
      end
    end else begin
      wl_s1_q <= wl_en_q;
      wl_s2_q <= wl_s1_q;
      ck_s1_q <= i_ck_level;
      ck_s2_q <= ck_s1_q;
      dqs_s1_q <= i_dqs;
      dqs_s2_q <= dqs_s1_q;
      dqs_s3_q <= dqs_s2_q;
      lvl_q <= lvl_d;
      fb_pipe_q <= fb_pipe_d;
    end
  end

  assign o_leveling = wl_s2_q;

  // Pin mux; calibration entry refused in leveling, but leveling entry during a burst is not blocked and the burst drives DQ
  assign o_dq = cal_drv_q ? cal_dq_q :
                {{8{fb_pipe_q[dtm_pkg::FB_CYC - 1][1]}},
                 {8{fb_pipe_q[dtm_pkg::FB_CYC - 1][0]}}};
  assign o_dq_oe = {16{cal_drv_q | wl_s2_q}};
  assign o_dmi = cal_dmi_q;
  assign o_dmi_oe = {2{cal_drv_q}};

  // ---------------- Checks ----------------
  sequence s_cal_issue;
    (state_q == CAL_IDLE) && i_cal_cmd && !wl_en_q ##1 i_cas2 && (i_cas2_op == 6'h00);
  endsequence

  sequence s_op_switch;
    i_mrw_valid && (i_mrw_addr == dtm_pkg::MRA_SP_CTRL) &&
      (i_mrw_data[dtm_pkg::OP_SEL_BIT] != op_sel_q);
  endsequence

  a_class_long: assert property (@(posedge i_ck_link) disable iff (!i_reset_n)
    (s_op_switch and (ref_q[0][6] != ref_q[1][6])) |=> class_q == dtm_pkg::CLASS_LONG)
    else $error("range change did not give long class");

  a_class_short: assert property (@(posedge i_ck_link) disable iff (!i_reset_n)
    (s_op_switch and ((ref_q[0][6] == ref_q[1][6]) &&
      (({1'b0, ref_q[0][5:0]} - {1'b0, ref_q[1][5:0]} == 7'h01) ||
       ({1'b0, ref_q[1][5:0]} - {1'b0, ref_q[0][5:0]} == 7'h01))))
      |=> class_q == dtm_pkg::CLASS_SHORT)
    else $error("one step change did not give short class");

  a_class_middle: assert property (@(posedge i_ck_link) disable iff (!i_reset_n)
    (s_op_switch and ((ref_q[0][6] == ref_q[1][6]) &&
      (({1'b0, ref_q[0][5:0]} > {1'b0, ref_q[1][5:0]} + 7'h01) ||
       ({1'b0, ref_q[1][5:0]} > {1'b0, ref_q[0][5:0]} + 7'h01))))
      |=> class_q == dtm_pkg::CLASS_MIDDLE)
    else $error("multi step change did not give middle class");

  a_wl_entry_exit: assert property (@(posedge i_ck_link) disable iff (!i_reset_n)
    i_mrw_valid && (i_mrw_addr == dtm_pkg::MRA_LAT_WL) |=>
      wl_en_q == $past(i_mrw_data[dtm_pkg::WL_EN_BIT]))
    else $error("leveling enable did not follow the write");

  a_cal_latency: assert property (@(posedge i_ck_link) disable iff (!i_reset_n)
    s_cal_issue |=> !cal_drv_q [*3] ##[1:8] (cal_drv_q && (beat_q == 4'h0)))
    else $error("burst did not start when latency expired");

  a_burst_length: assert property (@(posedge i_ck_link) disable iff (!i_reset_n)
    cal_drv_q && (beat_q == 4'hf) |=> !cal_drv_q ##1 !cal_drv_q)
    else $error("burst ran past sixteen beats");

  a_pin_invert: assert property (@(posedge i_ck_link) disable iff (!i_reset_n)
    cal_drv_q |-> o_dq == ({16{snap_pat_q[beat_q]}} ^ snap_msk_q))
    else $error("data pin inversion wrong");

  a_dmi_raw: assert property (@(posedge i_ck_link) disable iff (!i_reset_n)
    cal_drv_q |-> (o_dmi == {2{snap_pat_q[beat_q]}}) && o_dmi_oe == 2'h3)
    else $error("inversion applied on calibration output");

  a_fb_level: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    wl_s2_q && dqs_rise[0] ##1 wl_s2_q [*2] |=>
      o_dq[7:0] == {8{$past(ck_s2_q, dtm_pkg::FB_CYC + 1)}})
    else $error("leveling feedback does not match sampled clock");

endmodule // dtm_training

/* sim/dtm_ctl_model.sv */
// Purpose: Controller model: mode writes, calibration commands, strobes
// Assumes: Link inputs move at link falling edges, strobes at sys ones
// Notes:   A released write port shows the inverse of its last value
`timescale 1ns/1ps
module dtm_ctl_model #(
  parameter int EN_DLY = 4,
  parameter int PULSE_DLY = 8
) (
  // Clocks
  input wire logic i_clk_sys,
  input wire logic i_ck_link,
  // Command side
  output logic o_mrw_valid,
  output logic [5:0] o_mrw_addr,
  output logic [7:0] o_mrw_data,
  output logic o_cal_cmd,
  output logic o_cas2,
  output logic [5:0] o_cas2_op,
  // Strobes, parked low
  output logic [1:0] o_dqs
);
  // Idle levels at time zero
  initial begin
    o_mrw_valid = 1'b0;
    o_mrw_addr = 6'h00;
    o_mrw_data = 8'h00;
    o_cal_cmd = 1'b0;
    o_cas2 = 1'b0;
    o_cas2_op = 6'h00;
    o_dqs = 2'b00;
  end

  // One write, held through its taking edge; set-point switch is one write
  task automatic mrw(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_ck_link);
    o_mrw_valid = 1'b1;
    o_mrw_addr = a;
    o_mrw_data = d;
    @(posedge i_ck_link);
  endtask

  // Release the write port at the next link falling edge
  task automatic idle();
    @(negedge i_ck_link);
    o_mrw_valid = 1'b0;
    o_mrw_addr = ~o_mrw_addr;
    o_mrw_data = ~o_mrw_data;
  endtask

  // Command then second cycle at once, spaced from array reads
  task automatic cal(input logic [5:0] op);
    @(negedge i_ck_link);
    o_cal_cmd = 1'b1;
    @(posedge i_ck_link);
    @(negedge i_ck_link);
    o_cal_cmd = 1'b0;
    o_cas2 = 1'b1;
    o_cas2_op = op;
    @(posedge i_ck_link);
    @(negedge i_ck_link);
    o_cas2 = 1'b0;
    o_cas2_op = ~op;
  endtask

  // Park, wait both delays, then two pulses on the chosen input only
  task automatic level(input int idx);
    o_dqs = 2'b00;
    repeat (EN_DLY + PULSE_DLY) @(negedge i_clk_sys);
    repeat (2) begin
      o_dqs[idx] = 1'b1;
      repeat (3) @(negedge i_clk_sys);
      o_dqs[idx] = 1'b0;
      repeat (3) @(negedge i_clk_sys);
    end
  endtask
endmodule // dtm_ctl_model

/* sim/tb.sv */
// Purpose: Self-checking bench of the training-mode block
// Assumes: Link clock 160 ns, stopped low during leveling
// Notes:   Expectations are computed in the bench, never read from the DUT
`timescale 1ns/1ps
module tb;
  logic i_clk_sys = 1'b0;
  logic i_reset_n;
  logic ck_link = 1'b0;
  logic ck_run = 1'b1;
  logic ck_level;
  logic mrw_valid, cal_cmd, cas2, op_sp, wr_sp, ref_fast, cal_busy, leveling;
  logic [5:0] mrw_addr, cas2_op;
  logic [7:0] mrw_data;
  logic [1:0] dqs, dmi, dmi_oe, sw_class;
  logic [15:0] dq, dq_oe, pat, msk;
  logic [31:0] rnd = 32'h377a50ab;
  logic [6:0] ref1;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;

  // System clock, and a link clock of unrelated phase that stops low
  always #5 i_clk_sys = ~i_clk_sys;
  initial begin
    #3;
    forever begin
      #80;
      if (ck_run || ck_link) ck_link = ~ck_link;
    end
  end

  dtm_ctl_model u_ctl (.i_clk_sys(i_clk_sys), .i_ck_link(ck_link), .o_mrw_valid(mrw_valid),
    .o_mrw_addr(mrw_addr), .o_mrw_data(mrw_data), .o_cal_cmd(cal_cmd), .o_cas2(cas2),
    .o_cas2_op(cas2_op), .o_dqs(dqs));

  dtm_training u_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_ck_link(ck_link),
    .i_mrw_valid(mrw_valid), .i_mrw_addr(mrw_addr), .i_mrw_data(mrw_data),
    .i_cal_cmd(cal_cmd), .i_cas2(cas2), .i_cas2_op(cas2_op), .i_dqs(dqs),
    .i_ck_level(ck_level), .o_dq(dq), .o_dq_oe(dq_oe), .o_dmi(dmi), .o_dmi_oe(dmi_oe),
    .o_op_set_point(op_sp), .o_wr_set_point(wr_sp), .o_ref_fast(ref_fast),
    .o_switch_class(sw_class), .o_cal_busy(cal_busy), .o_leveling(leveling));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Beat k: pattern bit on every pin, mask inverts DQ only
  function automatic logic [17:0] beat(input logic [15:0] p, input logic [15:0] m, input int k);
    return {{2{p[k]}}, {16{p[k]}} ^ m};
  endfunction

  function automatic logic [1:0] sp_class(input logic [6:0] a, input logic [6:0] b);
    int d;
    d = int'(a[5:0]) - int'(b[5:0]);
    if (a[6] != b[6]) return dtm_pkg::CLASS_LONG;
    if (d == 1 || d == -1) return dtm_pkg::CLASS_SHORT;
    return (d == 0) ? dtm_pkg::CLASS_NONE : dtm_pkg::CLASS_MIDDLE;
  endfunction

  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Optionally program, then one burst; dup sends a refused second command
  task automatic cal_run(input logic [15:0] p, input logic [15:0] m, input logic [2:0] rl,
      input logic prog, input logic dup);
    int n;
    int lat;
    n = 0;
    lat = int'(rl) + int'(dtm_pkg::RL_BASE);
    if (prog) begin
      u_ctl.mrw(dtm_pkg::MRA_PAT_FIRST, p[7:0]);
      u_ctl.mrw(dtm_pkg::MRA_PAT_SECOND, p[15:8]);
      u_ctl.mrw(dtm_pkg::MRA_MASK_LO, m[7:0]);
      u_ctl.mrw(dtm_pkg::MRA_MASK_HI, m[15:8]);
      u_ctl.mrw(dtm_pkg::MRA_LAT_WL, {5'h00, rl});
      u_ctl.mrw(dtm_pkg::MRA_DBI, {1'b0, rnd[5], 6'h00});
      u_ctl.idle();
    end
    u_ctl.cal(6'h00);
    if (dup) begin
      u_ctl.cal(6'h00);
      n = 3;
    end
    while (dq_oe !== 16'hffff && n < 40) begin
      @(negedge ck_link);
      n++;
    end
    check("latency", 18'(n), 18'(lat));
    for (int k = 0; k < 16; k++) begin
      if (k > 0) @(negedge ck_link);
      check("beat", {dmi, dq}, beat(p, m, k));
      check("oe", {dmi_oe, dq_oe}, 18'h3ffff);
    end
    @(negedge ck_link);
    check("burst_end", 18'({cal_busy, dq_oe}), 18'h0);
    $display("test cal done");
  endtask

  // Leveling with the link clock stopped, each byte on its own
  task automatic lev_run(input logic [1:0] lvl);
    int n;
    n = 0;
    u_ctl.mrw(dtm_pkg::MRA_LAT_WL, 8'h80);
    u_ctl.idle();
    while (leveling !== 1'b1 && n < 20) begin
      @(negedge i_clk_sys);
      n++;
    end
    check("lev_oe", 18'(dq_oe), 18'hffff);
    ck_run = 1'b0;
    ck_level = ~lvl[0];
    u_ctl.level(0);
    ck_level = lvl[0];
    u_ctl.level(0);
    ck_level = lvl[1];
    u_ctl.level(1);
    repeat (10) @(negedge i_clk_sys);
    check("lev_fb", 18'(dq), 18'({{8{lvl[1]}}, {8{lvl[0]}}}));
    ck_run = 1'b1;
    u_ctl.mrw(dtm_pkg::MRA_LAT_WL, 8'h00);
    u_ctl.idle();
    n = 0;
    while (leveling !== 1'b0 && n < 20) begin
      @(negedge i_clk_sys);
      n++;
    end
    repeat (4) @(negedge i_clk_sys);
    check("lev_exit", 18'({dq, dq_oe[0]}), 18'h0);
    $display("test leveling done");
  endtask

  // Cycle ceiling cuts a hang short
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    i_reset_n = 1'b0;
    ck_level = 1'b0;
    repeat (5) @(posedge ck_link);
    @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    check("reset", 18'({op_sp, wr_sp, sw_class, cal_busy, leveling, dq_oe, dmi_oe}), 18'h0);
    cal_run(16'h3c5a, 16'h5555, 3'h0, 1'b0, 1'b0);
    cal_run(16'h591c, 16'hffff, 3'h7, 1'b1, 1'b1);
    cal_run(16'hffff, 16'h0000, 3'h0, 1'b1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      pat = rnd[15:0];
      msk = rnd[31:16];
      rnd = lfsr(lfsr(rnd));
      cal_run(pat, msk, rnd[2:0], 1'b1, rnd[3]);
    end
    u_ctl.cal(6'h21);
    pat = 16'h0000;
    repeat (20) begin
      @(negedge ck_link);
      pat = pat | 16'({dq_oe[0], cal_busy});
    end
    check("drop", 18'(pat), 18'h0);
    // Copy 0 reference, then copy 1 rewritten per case
    u_ctl.mrw(dtm_pkg::MRA_REF, 8'h0c);
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      ref1 = (i == 0) ? 7'h0d : (i == 1) ? 7'h0b : (i == 2) ? 7'h0e :
             (i == 3) ? 7'h0e + 7'(rnd[3:0]) : {1'b1, rnd[5:0]};
      u_ctl.mrw(dtm_pkg::MRA_SP_CTRL, 8'h40);
      u_ctl.mrw(dtm_pkg::MRA_REF, {1'b0, ref1});
      u_ctl.mrw(dtm_pkg::MRA_SP_CTRL, 8'hc8);
      u_ctl.idle();
      check("sw_to1", 18'({op_sp, wr_sp, ref_fast, sw_class}),
        18'({3'b111, sp_class(7'h0c, ref1)}));
      u_ctl.mrw(dtm_pkg::MRA_SP_CTRL, 8'h08);
      u_ctl.idle();
      check("sw_to0", 18'({op_sp, wr_sp, ref_fast, sw_class}),
        18'({3'b001, sp_class(ref1, 7'h0c)}));
      u_ctl.mrw(dtm_pkg::MRA_SP_CTRL, 8'h00);
      u_ctl.idle();
      check("sw_norm", 18'({op_sp, wr_sp, ref_fast}), 18'h0);
    end
    $display("test set-point done");
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      lev_run(rnd[1:0]);
    end
    report_and_stop();
  end
endmodule // tb
